/* File: inc/dma_pkg.sv */
package dma_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int AW  = 24;
  localparam int CW  = 18;
  localparam int ADW = 8;

  // ----------------------------------------------------------------
  // register map: adr[7] global, adr[6:5] channel, adr[4:0] offset
  // ----------------------------------------------------------------
  localparam int          GLB_BIT  = 7;
  localparam int          CH_LSB   = 5;
  localparam logic [4:0]  OFF_CTRL = 5'h00;
  localparam logic [4:0]  OFF_SRC  = 5'h04;
  localparam logic [4:0]  OFF_DST  = 5'h08;
  localparam logic [4:0]  OFF_BLK  = 5'h0c;
  localparam logic [4:0]  OFF_REP  = 5'h10;
  localparam logic [4:0]  OFF_STAT = 5'h14;
  localparam logic [4:0]  OFF_PRIO = 5'h00;

  // ctrl fields
  localparam int C_START = 0;
  localparam int C_SWREQ = 1;
  localparam int C_BURST = 2;
  localparam int C_SMODE = 4;
  localparam int C_DMODE = 6;
  localparam int C_SRLD  = 8;
  localparam int C_DRLD  = 10;
  localparam int C_TRIG  = 12;
  localparam int C_LINK  = 14;
  localparam int C_CRC   = 15;
  localparam int C_IEDN  = 16;
  localparam int C_IEER  = 17;

  // stat fields
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_ERR  = 2;

  // reset values
  localparam logic [CW-1:0] CTRL_RST = 18'h00000;
  localparam logic [15:0]   BLK_RST  = 16'h0001;
  localparam logic [7:0]    REP_RST  = 8'h01;

  typedef enum logic [1:0] {
    AM_FIXED = 2'b00,
    AM_INC   = 2'b01,
    AM_DEC   = 2'b10
  } amode_type;

  typedef enum logic [1:0] {
    RL_NONE  = 2'b00,
    RL_BURST = 2'b01,
    RL_BLOCK = 2'b10,
    RL_TXN   = 2'b11
  } reload_type;

  typedef enum logic [1:0] {
    TR_SW     = 2'b00,
    TR_PERIPH = 2'b01,
    TR_EVENT  = 2'b10
  } trig_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b10
  } state_type;
endpackage

/* File: logic/dma_ctrl.sv */
`timescale 1ns/1ps
module dma_ctrl #(
  parameter int AW = dma_pkg::AW
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [dma_pkg::ADW-1:0]  adr_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  input  wire logic                     we_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  output logic                          ack_o,
  output logic                          rd_req_o,
  output logic      [AW-1:0]            rd_addr_o,
  input  wire logic [7:0]               rd_data_i,
  input  wire logic                     rd_ack_i,
  input  wire logic                     rd_err_i,
  output logic                          wr_req_o,
  output logic      [AW-1:0]            wr_addr_o,
  output logic      [7:0]               wr_data_o,
  input  wire logic                     wr_ack_i,
  input  wire logic                     wr_err_i,
  input  wire logic [dma_pkg::NCH-1:0]  periph_req_i,
  input  wire logic [dma_pkg::NCH-1:0]  event_i,
  output logic      [dma_pkg::NCH-1:0]  irq_o,
  output logic                          crc_valid_o,
  output logic      [7:0]               crc_data_o
);
  localparam int NCH = dma_pkg::NCH;
  localparam int CW  = dma_pkg::CW;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [CW-1:0]         ctrl_r [NCH];
  logic [AW-1:0]         src_r  [NCH];
  logic [AW-1:0]         dst_r  [NCH];
  logic [15:0]           blk_r  [NCH];
  logic [7:0]            rep_r  [NCH];
  logic                  rr_r;
  logic [AW-1:0]         csrc_r [NCH];
  logic [AW-1:0]         cdst_r [NCH];
  logic [16:0]           bleft_r[NCH];
  logic [8:0]            rleft_r[NCH];
  logic [NCH-1:0]        active_r;
  logic [NCH-1:0]        pend_r;
  logic [NCH-1:0]        done_r;
  logic [NCH-1:0]        err_r;
  dma_pkg::state_type    state_r;
  logic [1:0]            ch_r;
  logic [1:0]            last_r;
  logic [3:0]            bcnt_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                  acc;
  logic                  wacc;
  logic                  glb;
  logic [1:0]            wch;
  logic [4:0]            off;
  logic [NCH-1:0]        start_w;
  logic [NCH-1:0]        swreq_w;
  logic [NCH-1:0]        clr_dn;
  logic [NCH-1:0]        clr_er;
  logic [31:0]           rdat;

  assign acc = cyc_i & stb_i & ~ack_o;
  // writes land at the edge where the master sees ack, never earlier
  assign wacc = cyc_i & stb_i & we_i & ack_o;
  assign glb = adr_i[dma_pkg::GLB_BIT];
  assign wch = adr_i[dma_pkg::CH_LSB +: 2];
  assign off = adr_i[4:0];

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    start_w = '0;
    swreq_w = '0;
    clr_dn  = '0;
    clr_er  = '0;
    if (wacc && !glb) begin
      if (off == dma_pkg::OFF_CTRL && sel_i[0]) begin
        start_w[wch] = dat_i[dma_pkg::C_START];
        swreq_w[wch] = dat_i[dma_pkg::C_SWREQ];
      end
      if (off == dma_pkg::OFF_STAT && sel_i[0]) begin
        clr_dn[wch] = dat_i[dma_pkg::S_DONE];
        clr_er[wch] = dat_i[dma_pkg::S_ERR];
      end
    end
  end

  always_comb begin
    rdat = '0;
    if (glb) begin
      if (off == dma_pkg::OFF_PRIO) begin
        rdat[0] = rr_r;
      end
    end else begin
      unique case (off)
        dma_pkg::OFF_CTRL: begin
          rdat[CW-1:0] = ctrl_r[wch];
          rdat[dma_pkg::C_START] = active_r[wch];
          rdat[dma_pkg::C_SWREQ] = pend_r[wch];
        end
        dma_pkg::OFF_SRC:  rdat[AW-1:0] = src_r[wch];
        dma_pkg::OFF_DST:  rdat[AW-1:0] = dst_r[wch];
        dma_pkg::OFF_BLK:  rdat[15:0] = blk_r[wch];
        dma_pkg::OFF_REP:  rdat[7:0] = rep_r[wch];
        dma_pkg::OFF_STAT: rdat[2:0] = {err_r[wch], done_r[wch], active_r[wch]};
        default:           rdat = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, unmapped reads 0
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= acc;
      dat_o <= acc ? rdat : '0;
    end
  end

  // per-channel configuration, separate copy for each channel, plus the global priority bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rr_r <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        ctrl_r[c] <= dma_pkg::CTRL_RST;
        src_r[c]  <= '0;
        dst_r[c]  <= '0;
        blk_r[c]  <= dma_pkg::BLK_RST;
        rep_r[c]  <= dma_pkg::REP_RST;
      end
    end else if (wacc) begin
      if (glb) begin
        if (off == dma_pkg::OFF_PRIO && sel_i[0]) begin
          rr_r <= dat_i[0];
        end
      end else begin
        unique case (off)
          dma_pkg::OFF_CTRL: ctrl_r[wch] <= CW'(merge(32'(ctrl_r[wch]), dat_i, sel_i));
          dma_pkg::OFF_SRC:  src_r[wch] <= AW'(merge(32'(src_r[wch]), dat_i, sel_i));
          dma_pkg::OFF_DST:  dst_r[wch] <= AW'(merge(32'(dst_r[wch]), dat_i, sel_i));
          dma_pkg::OFF_BLK:  blk_r[wch] <= 16'(merge(32'(blk_r[wch]), dat_i, sel_i));
          dma_pkg::OFF_REP:  rep_r[wch] <= 8'(merge(32'(rep_r[wch]), dat_i, sel_i));
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [NCH-1:0] cand;
  logic [NCH-1:0] trg_w;
  logic           gv;
  logic [1:0]     gch;
  logic [1:0]     idx;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      unique case (dma_pkg::trig_type'(ctrl_r[c][dma_pkg::C_TRIG +: 2]))
        dma_pkg::TR_PERIPH: trg_w[c] = active_r[c] & periph_req_i[c];
        dma_pkg::TR_EVENT:  trg_w[c] = active_r[c] & event_i[c];
        default:            trg_w[c] = 1'b0;
      endcase
      cand[c] = active_r[c] & (pend_r[c] | trg_w[c]);
    end
    gv  = 1'b0;
    gch = '0;
    idx = '0;
    for (int i = 0; i < NCH; i++) begin
      idx = rr_r ? 2'(last_r + 2'(i + 1)) : 2'(i);
      if (!gv && cand[idx]) begin
        gv  = 1'b1;
        gch = idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // byte step helpers
  // ----------------------------------------------------------------
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [1:0] m);
    unique case (dma_pkg::amode_type'(m))
      dma_pkg::AM_INC: step = AW'(a + 1'b1);
      dma_pkg::AM_DEC: step = AW'(a - 1'b1);
      default:         step = a;
    endcase
  endfunction

  function automatic logic reload(input logic [1:0] m, input logic b, input logic k,
                                  input logic t);
    unique case (dma_pkg::reload_type'(m))
      dma_pkg::RL_BURST: reload = b;
      dma_pkg::RL_BLOCK: reload = k;
      dma_pkg::RL_TXN:   reload = t;
      default:           reload = 1'b0;
    endcase
  endfunction

  logic [CW-1:0] cc;
  logic          b_end;
  logic          k_end;
  logic          t_end;
  logic [AW-1:0] nsrc;
  logic [NCH-1:0] link_w;

  assign cc    = ctrl_r[ch_r];
  assign k_end = bleft_r[ch_r] == 17'h00001;
  assign b_end = bcnt_r == 4'h1 || k_end;
  assign t_end = k_end && rleft_r[ch_r] == 9'h001;
  assign nsrc  = reload(cc[dma_pkg::C_SRLD +: 2], b_end, k_end, t_end) ? src_r[ch_r]
                 : step(csrc_r[ch_r], cc[dma_pkg::C_SMODE +: 2]);

  always_comb begin
    link_w = '0;
    if (state_r == dma_pkg::ST_WR && wr_ack_i && !wr_err_i && t_end
        && cc[dma_pkg::C_LINK]) begin
      link_w[ch_r ^ 2'b01] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transfer engine and channel run state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= dma_pkg::ST_IDLE;
      ch_r      <= '0;
      last_r    <= '0;
      bcnt_r    <= '0;
      active_r  <= '0;
      pend_r    <= '0;
      done_r    <= '0;
      err_r     <= '0;
      rd_req_o  <= 1'b0;
      rd_addr_o <= '0;
      wr_req_o  <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      crc_valid_o <= 1'b0;
      crc_data_o  <= '0;
      for (int c = 0; c < NCH; c++) begin
        csrc_r[c]  <= '0;
        cdst_r[c]  <= '0;
        bleft_r[c] <= '0;
        rleft_r[c] <= '0;
      end
    end else begin
      crc_valid_o <= 1'b0;
      // set wins over software clear
      done_r <= done_r & ~clr_dn;
      err_r  <= err_r & ~clr_er;
      // a trigger seen while the engine is busy on another channel is kept, not lost
      pend_r <= pend_r | swreq_w | trg_w;
      unique case (state_r)
        dma_pkg::ST_IDLE: begin
          if (gv) begin
            ch_r      <= gch;
            last_r    <= gch;
            bcnt_r    <= 4'(4'h1 << ctrl_r[gch][dma_pkg::C_BURST +: 2]);
            rd_req_o  <= 1'b1;
            rd_addr_o <= csrc_r[gch];
            pend_r[gch] <= 1'b1;
            state_r   <= dma_pkg::ST_RD;
          end
        end
        dma_pkg::ST_RD: begin
          // read latency differs by target; the ack alone paces it
          if (rd_err_i) begin
            rd_req_o <= 1'b0;
            active_r[ch_r] <= 1'b0;
            err_r[ch_r] <= 1'b1;
            state_r <= dma_pkg::ST_IDLE;
          end else if (rd_ack_i) begin
            rd_req_o  <= 1'b0;
            wr_req_o  <= 1'b1;
            wr_addr_o <= cdst_r[ch_r];
            wr_data_o <= rd_data_i;
            state_r   <= dma_pkg::ST_WR;
          end
        end
        dma_pkg::ST_WR: begin
          if (wr_err_i) begin
            wr_req_o <= 1'b0;
            active_r[ch_r] <= 1'b0;
            err_r[ch_r] <= 1'b1;
            state_r <= dma_pkg::ST_IDLE;
          end else if (wr_ack_i) begin
            wr_req_o <= 1'b0;
            crc_valid_o <= cc[dma_pkg::C_CRC];
            crc_data_o  <= wr_data_o;
            csrc_r[ch_r] <= nsrc;
            cdst_r[ch_r] <= reload(cc[dma_pkg::C_DRLD +: 2], b_end, k_end, t_end)
                            ? dst_r[ch_r] : step(cdst_r[ch_r], cc[dma_pkg::C_DMODE +: 2]);
            bcnt_r <= 4'(bcnt_r - 1'b1);
            bleft_r[ch_r] <= 17'(bleft_r[ch_r] - 1'b1);
            if (k_end) begin
              bleft_r[ch_r] <= (blk_r[ch_r] == 16'h0000) ? 17'h10000 : 17'(blk_r[ch_r]);
              rleft_r[ch_r] <= 9'(rleft_r[ch_r] - 1'b1);
              pend_r[ch_r]  <= swreq_w[ch_r] | trg_w[ch_r];
            end
            if (t_end) begin
              active_r[ch_r] <= 1'b0;
              done_r[ch_r]   <= 1'b1;
            end
            if (b_end) begin
              // the burst is never split by another channel, so the grant is revisited only here and after a read or write error
              state_r <= dma_pkg::ST_IDLE;
            end else begin
              rd_req_o  <= 1'b1;
              rd_addr_o <= nsrc;
              state_r   <= dma_pkg::ST_RD;
            end
          end
        end
        default: state_r <= dma_pkg::ST_IDLE;
      endcase
      // a start overrides any step made above on the same channel
      for (int c = 0; c < NCH; c++) begin
        if (start_w[c] || link_w[c]) begin
          active_r[c] <= 1'b1;
          csrc_r[c]   <= src_r[c];
          cdst_r[c]   <= dst_r[c];
          bleft_r[c]  <= (blk_r[c] == 16'h0000) ? 17'h10000 : 17'(blk_r[c]);
          rleft_r[c]  <= (rep_r[c] == 8'h00) ? 9'h100 : 9'(rep_r[c]);
          pend_r[c]   <= swreq_w[c] | link_w[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel interrupt lines
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        irq_o[c] <= (done_r[c] & ctrl_r[c][dma_pkg::C_IEDN])
                  | (err_r[c] & ctrl_r[c][dma_pkg::C_IEER]);
      end
    end
  end
endmodule // dma_ctrl

/* File: sim/dma_ctrl_sva.sv */
`timescale 1ns/1ps
module dma_ctrl_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        rd_req_o,
  input wire logic [23:0] rd_addr_o,
  input wire logic        rd_ack_i,
  input wire logic        rd_err_i,
  input wire logic        wr_req_o,
  input wire logic [23:0] wr_addr_o,
  input wire logic [7:0]  wr_data_o,
  input wire logic        wr_ack_i,
  input wire logic        wr_err_i,
  input wire logic [3:0]  irq_o,
  input wire logic        crc_valid_o,
  input wire logic [7:0]  crc_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data driven outside ack");
  a_reset_quiet: assert property ($fell(rst_i) |-> !rd_req_o && !wr_req_o && !ack_o
    && irq_o == 4'h0 && !crc_valid_o)
    else $error("outputs active after reset");
  // ------------------------------------------------------------
  // memory ports
  // ------------------------------------------------------------
  a_rd_hold: assert property (rd_req_o && !rd_ack_i && !rd_err_i |=>
    rd_req_o && $stable(rd_addr_o))
    else $error("read request not held");
  a_rd_release: assert property (rd_req_o && (rd_ack_i || rd_err_i) |=> !rd_req_o)
    else $error("read request kept after answer");
  a_wr_hold: assert property (wr_req_o && !wr_ack_i && !wr_err_i |=>
    wr_req_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write request not held");
  a_wr_release: assert property (wr_req_o && (wr_ack_i || wr_err_i) |=> !wr_req_o)
    else $error("write request kept after answer");
  a_wr_order: assert property ($rose(wr_req_o) |->
    $past(rd_req_o && rd_ack_i && !rd_err_i))
    else $error("write without a completed read");
  a_crc_copy: assert property (crc_valid_o |->
    $past(wr_req_o && wr_ack_i) && crc_data_o == $past(wr_data_o))
    else $error("checksum byte not the byte written");
endmodule // dma_ctrl_sva

/* File: sim/dma_mem_model.sv */
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic [23:0] bad_i,
  input  wire logic        rd_req_i,
  input  wire logic [23:0] rd_addr_i,
  output logic      [7:0]  rd_data_o,
  output logic             rd_ack_o,
  output logic             rd_err_o,
  input  wire logic        wr_req_i,
  input  wire logic [23:0] wr_addr_i,
  input  wire logic [7:0]  wr_data_i,
  output logic             wr_ack_o,
  output logic             wr_err_o
);
  logic [7:0] mem [0:4095];
  logic [3:0] rcnt_r;
  logic [3:0] wcnt_r;
  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  // lat 0 answers the cycle after the request, never two cycles running; data toggles when not answering
  always_ff @(posedge clk_i) begin
    rd_ack_o  <= 1'b0;
    rd_err_o  <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (rst_i) begin
      rcnt_r    <= 4'h0;
      rd_data_o <= 8'h00;
    end else if (rd_req_i && !rd_ack_o && !rd_err_o) begin
      if (rcnt_r < lat_i) begin
        rcnt_r <= rcnt_r + 4'h1;
      end else begin
        rcnt_r    <= 4'h0;
        rd_err_o  <= (rd_addr_i == bad_i);
        rd_ack_o  <= (rd_addr_i != bad_i);
        rd_data_o <= mem[rd_addr_i[11:0]];
      end
    end
  end
  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  // plain always: the bench preloads mem, so no always_ff may own it
  always @(posedge clk_i) begin
    wr_ack_o <= 1'b0;
    wr_err_o <= 1'b0;
    if (rst_i) begin
      wcnt_r <= 4'h0;
    end else if (wr_req_i && !wr_ack_o && !wr_err_o) begin
      if (wcnt_r < lat_i) begin
        wcnt_r <= wcnt_r + 4'h1;
      end else begin
        wcnt_r   <= 4'h0;
        wr_err_o <= (wr_addr_i == bad_i);
        wr_ack_o <= (wr_addr_i != bad_i);
        if (wr_addr_i != bad_i) begin
          mem[wr_addr_i[11:0]] <= wr_data_i;
        end
      end
    end
  end
endmodule // dma_mem_model

/* File: sim/test_four_channel_dma_controller.sv */
`timescale 1ns/1ps
module test_four_channel_dma_controller;
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [3:0]  sel_i = 4'hf, periph_req_i = 4'h0, event_i = 4'h0, irq_o, lat = 4'h0;
  logic        ack_o, rd_req_o, rd_ack_i, rd_err_i, wr_req_o, wr_ack_i, wr_err_i;
  logic        crc_valid_o;
  logic [23:0] rd_addr_o, wr_addr_o, bad = 24'hfff000;
  logic [7:0]  rd_data_i, wr_data_o, crc_data_o;
  int          fail_count = 0, checks_done = 0, crc_n = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (crc_valid_o === 1'b1) crc_n <= crc_n + 1;
  dma_ctrl dma_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .rd_ack_i(rd_ack_i),
    .rd_err_i(rd_err_i), .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_ack_i(wr_ack_i), .wr_err_i(wr_err_i), .periph_req_i(periph_req_i),
    .event_i(event_i), .irq_o(irq_o), .crc_valid_o(crc_valid_o), .crc_data_o(crc_data_o));
  dma_mem_model dma_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .bad_i(bad),
    .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i), .rd_ack_o(rd_ack_i),
    .rd_err_o(rd_err_i), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .wr_ack_o(wr_ack_i), .wr_err_o(wr_err_i));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] iv(input int a);
    iv = 8'(a) ^ 8'h5a;
  endfunction
  function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
    ra = {1'b0, 2'(ch), off};
  endfunction
  // crc feed and both irq enables always on; swreq only for software trigger
  function automatic logic [31:0] cf(input logic [1:0] b, sm, dm, sr, tr, input logic go, lk);
    cf = 32'h38000 | 32'(go) | (32'(go && tr == 2'd0) << dma_pkg::C_SWREQ)
      | (32'(b) << dma_pkg::C_BURST) | (32'(sm) << dma_pkg::C_SMODE)
      | (32'(dm) << dma_pkg::C_DMODE) | (32'(sr) << dma_pkg::C_SRLD)
      | (32'(tr) << dma_pkg::C_TRIG) | (32'(lk) << dma_pkg::C_LINK);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic setup(input int ch, input int s, d, blk, input logic [31:0] c);
    wb(ra(ch, dma_pkg::OFF_SRC), 1'b1, 32'(s));
    wb(ra(ch, dma_pkg::OFF_DST), 1'b1, 32'(d));
    wb(ra(ch, dma_pkg::OFF_BLK), 1'b1, 32'(blk));
    wb(ra(ch, dma_pkg::OFF_CTRL), 1'b1, c);
  endtask
  task automatic wait_st(input int ch);
    int n = 0;
    do wb(ra(ch, dma_pkg::OFF_STAT), 1'b0, 32'h0); while (q[2:1] == 2'b00 && n++ < 200);
  endtask
  task automatic chm(input int a, input logic [7:0] e);
    chk("memory byte", {24'h0, dma_mem_model_inst.mem[a]}, {24'h0, e});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    for (int ch = 0; ch < 4; ch++) begin
      rdc(ra(ch, dma_pkg::OFF_CTRL), 32'h0, "ctrl reset");
      rdc(ra(ch, dma_pkg::OFF_BLK), 32'h1, "block reset");
      rdc(ra(ch, dma_pkg::OFF_REP), 32'h1, "repeat reset");
      rdc(ra(ch, dma_pkg::OFF_STAT), 32'h0, "status reset");
    end
    wb(ra(2, dma_pkg::OFF_SRC), 1'b1, 32'h123);
    rdc(ra(3, dma_pkg::OFF_SRC), 32'h0, "other channel source");
    rdc(ra(2, dma_pkg::OFF_SRC), 32'h123, "own source");
    wb(8'h9c, 1'b1, 32'hff);
    rdc(8'h9c, 32'h0, "unmapped");
    rdc(8'h80, 32'h0, "priority reset");
    wb(8'h80, 1'b1, 32'h1);
    rdc(8'h80, 32'h1, "priority round robin");
    wb(8'h80, 1'b1, 32'h0);
  endtask
  task automatic t_copy();
    int c0 = crc_n;
    setup(0, 'h100, 'h200, 7, cf(2'd3, 2'd1, 2'd1, 2'd0, 2'd0, 1'b1, 1'b0));
    wait_st(0);
    chk("done status", q, 32'h2);
    chk("irq raised", {28'h0, irq_o}, 32'h1);
    for (int i = 0; i < 7; i++) chm('h200 + i, iv('h100 + i));
    chm('h207, iv('h207));
    chk("checksum bytes", 32'(crc_n - c0), 32'd7);
    wb(ra(0, dma_pkg::OFF_STAT), 1'b1, 32'h7);
    // flag clears at the ack edge, the irq line one cycle later
    repeat (2) @(posedge clk_i);
    chk("irq cleared", {28'h0, irq_o}, 32'h0);
  endtask
  task automatic t_reload();
    lat <= 4'h2;
    setup(1, 'h300, 'h403, 4, cf(2'd1, 2'd1, 2'd2, 2'd1, 2'd0, 1'b1, 1'b0));
    wait_st(1);
    for (int i = 0; i < 4; i++) chm('h403 - i, iv('h300 + i % 2));
    wb(ra(1, dma_pkg::OFF_STAT), 1'b1, 32'h7);
  endtask
  task automatic t_trig();
    lat <= 4'h1;
    setup(1, 'h500, 'h600, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd1, 1'b1, 1'b0));
    setup(2, 'h501, 'h601, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd2, 1'b1, 1'b0));
    setup(3, 'h502, 'h602, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 1'b1, 1'b0));
    periph_req_i <= 4'h2;
    event_i      <= 4'h4;
    @(posedge clk_i);
    event_i <= 4'h0;
    for (int ch = 1; ch < 4; ch++) wait_st(ch);
    periph_req_i <= 4'h0;
    for (int ch = 1; ch < 4; ch++) chm('h600 + ch - 1, iv('h500 + ch - 1));
    chk("three irqs", {28'h0, irq_o}, 32'he);
    for (int ch = 1; ch < 4; ch++) wb(ra(ch, dma_pkg::OFF_STAT), 1'b1, 32'h7);
  endtask
  task automatic t_err();
    bad <= 24'h000777;
    setup(0, 'h777, 'h210, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 1'b1, 1'b0));
    wait_st(0);
    chk("error flag", {31'h0, q[2]}, 32'h1);
    chk("error irq", {31'h0, irq_o[0]}, 32'h1);
    chm('h210, iv('h210));
    wb(ra(0, dma_pkg::OFF_STAT), 1'b1, 32'h7);
    setup(0, 'h211, 'h777, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 1'b1, 1'b0));
    wait_st(0);
    chk("write error flag", {31'h0, q[2]}, 32'h1);
    chm('h777, iv('h777));
    wb(ra(0, dma_pkg::OFF_STAT), 1'b1, 32'h7);
  endtask
  task automatic t_link();
    lat <= 4'h0;
    setup(1, 'h700, 'h710, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 1'b0, 1'b0));
    setup(0, 'h720, 'h730, 1, cf(2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 1'b1, 1'b1));
    wait_st(0);
    wait_st(1);
    chk("partner done", {30'h0, q[2:1]}, 32'h1);
    chm('h730, iv('h720));
    chm('h710, iv('h700));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) dma_mem_model_inst.mem[i] = iv(i);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_copy();
    t_reload();
    t_trig();
    t_err();
    t_link();
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule // test_four_channel_dma_controller
bind dma_ctrl dma_ctrl_sva dma_ctrl_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
  .rd_ack_i(rd_ack_i), .rd_err_i(rd_err_i), .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o),
  .wr_data_o(wr_data_o), .wr_ack_i(wr_ack_i), .wr_err_i(wr_err_i), .irq_o(irq_o),
  .crc_valid_o(crc_valid_o), .crc_data_o(crc_data_o));
